// *** sad_map.svh ***
// address map constants for the system address decoder
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH
`define SAD_MMR_END 24'h00_00C0
`define SAD_DUAL_BASE 24'h00_00C0
`define SAD_SINGLE_BASE 24'h01_0000
`define SAD_RSV_BASE 24'h04_0000
`define SAD_CS2_BASE 24'h80_0000
`define SAD_CS3_BASE 24'hC0_0000
`define SAD_CS4_BASE 24'hE0_0000
`define SAD_CS5_BASE 24'hF0_0000
`define SAD_ROM_BASE 24'hFE_0000
`define SAD_ROM_END 24'hFF_FFFF
`define SAD_DUAL_BLOCKS 8
`define SAD_SINGLE_BLOCKS 24
`define SAD_BLOCK_WORDS 4096
`define SAD_EXT_ADDR_BITS 21
`define SAD_DMA_EXT_ID 2'd3
`define SAD_IO_I2C_LO 16'h1A00
`define SAD_IO_I2C_HI 16'h1A6C
`define SAD_IO_UART_LO 16'h1B00
`define SAD_IO_UART_HI 16'h1B1F
`define SAD_IO_I2S_LO 16'h2800
`define SAD_IO_I2S_HI 16'h2B40
`define SAD_IO_MMC_LO 16'h3A00
`define SAD_IO_MMC_HI 16'h3B1F
`define SAD_IO_EXT_LO 16'h1000
`define SAD_IO_EXT_HI 16'h10DD
`define SAD_IO_USB_LO 16'h8000
`endif

// *** sad_pkg.sv ***
// types shared by the system address decoder
package sad_pkg;
   typedef enum logic [2:0] {
      SAD_M_CPU,
      SAD_M_DMA0,
      SAD_M_DMA1,
      SAD_M_DMA2,
      SAD_M_DMA3,
      SAD_M_USB
   } sad_master_e;
   typedef enum logic [3:0] {
      SAD_T_NONE,
      SAD_T_DUAL,
      SAD_T_SINGLE,
      SAD_T_ROM,
      SAD_T_CS2,
      SAD_T_CS3,
      SAD_T_CS4,
      SAD_T_CS5,
      SAD_T_IO
   } sad_target_e;
   typedef struct packed {
      logic valid;
      sad_master_e master;
      logic io;
      logic [23:0] addr;
   } sad_req_s;
   typedef struct packed {
      logic valid;
      sad_target_e target;
      logic [3:0] cs;
      logic [4:0] block;
      logic [20:0] ext_addr;
      logic [15:0] io_addr;
      logic miss;
   } sad_rsp_s;
endpackage

// *** sad_single_arb.sv ***
// per-block arbiter serialising two ports onto one single-access block
`timescale 1ns/100ps
`default_nettype none
module sad_single_arb (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic req_a_i,
   input wire logic req_b_i,
   output logic grant_a_o,
   output logic grant_b_o
);
   logic prio_b_q;
   logic prio_b_d;
   wire both = req_a_i & req_b_i;
   // alternate priority so neither port starves under steady contention
   assign grant_a_o = req_a_i & (~req_b_i | ~prio_b_q);
   assign grant_b_o = req_b_i & (~req_a_i | prio_b_q);
   assign prio_b_d = both ? ~prio_b_q : prio_b_q;
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         prio_b_q <= 1'b0;
      end else begin
         prio_b_q <= prio_b_d;
      end
   end
   a_single_one_grant: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      !(grant_a_o && grant_b_o)) else $error("two grants to one block"); // see R7
   a_single_alt_prio: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (both && grant_a_o) ##1 both |-> grant_b_o) else $error("no alternation"); // see R7
endmodule
`default_nettype wire

// *** sad_decoder.sv ***
// two-port system address decoder with ROM remap and master restrictions
// Operation
// R1 - CS2, CS3, CS4 regions start at 800000h, C00000h, E00000h.
// R2 - CS5 starts F00000h, ending below ROM when ROM mapped in.
// R3 - each external region has its own select, asserted only for it.
// R4 - FE0000h-FFFFFFh goes to ROM if remap clear, else to CS5.
// R5 - lowest 192 bytes reserved for core registers; dual RAM follows.
// R6 - dual RAM is 8 blocks of 4K words, two accesses per cycle.
// R7 - single RAM is 24 blocks of 4K words, contenders serialised.
// R8 - only DMA controller 3 may reach external regions; the decoder also lets the CPU reach them.
// R9 - USB controller may not reach dual RAM.
// R10 - separate 64K-byte I/O space reached by I/O cycles or DMA.
// R11 - masters must not touch unused I/O addresses.
// R12 - DMA I/O access limited to serial, card, memory-interface, USB windows.
// R13 - masters check peripheral reset and clock gating before access.
// R14 - external path: 16 or 8 bit data, 21 address bits, four selects.
// R15 - total decoded memory space is 16M bytes.
// R16 - hardware reset clears the ROM remap bit.
// R17 - software reset leaves the ROM remap bit alone.
// R18 - reserved-region access selects nothing and reports a miss.
`timescale 1ns/100ps
`default_nettype none
`include "sad_map.svh"
module sad_decoder (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic soft_rst_i,
   input wire logic remap_wr_i,
   input wire logic remap_val_i,
   input wire logic ext_bus8_i,
   input wire sad_pkg::sad_req_s req_a_i,
   input wire sad_pkg::sad_req_s req_b_i,
   output logic rom_remap_bit_o,
   output logic ext_bus8_o,
   output sad_pkg::sad_rsp_s rsp_a_o,
   output sad_pkg::sad_rsp_s rsp_b_o,
   output logic stall_a_o,
   output logic stall_b_o,
   output logic [3:0] external_region_select_o
);
   logic rom_remap_bit_q;
   logic bus8_q;
   sad_pkg::sad_rsp_s rsp_a_q;
   sad_pkg::sad_rsp_s rsp_b_q;
   logic stall_a_q;
   logic stall_b_q;
   logic [3:0] sel_q;

   // io window check: cpu sees the whole space, dma only listed windows
   function automatic logic io_ok(input sad_pkg::sad_master_e m, input logic [15:0] w);
      logic dma;
      logic win;
      dma = (m != sad_pkg::SAD_M_CPU) && (m != sad_pkg::SAD_M_USB);
      win = (w >= `SAD_IO_I2C_LO && w <= `SAD_IO_I2C_HI)
         | (w >= `SAD_IO_UART_LO && w <= `SAD_IO_UART_HI)
         | (w >= `SAD_IO_I2S_LO && w <= `SAD_IO_I2S_HI)
         | (w >= `SAD_IO_MMC_LO && w <= `SAD_IO_MMC_HI)
         | (w >= `SAD_IO_EXT_LO && w <= `SAD_IO_EXT_HI)
         | (w >= `SAD_IO_USB_LO);
      io_ok = (m == sad_pkg::SAD_M_CPU) || (dma && win); // see R10 R12
   endfunction

   // combinational decode of one request into a response
   function automatic sad_pkg::sad_rsp_s decode(input sad_pkg::sad_req_s r,
                                               input logic remap);
      sad_pkg::sad_rsp_s o;
      logic [23:0] a;
      logic ext_ok;
      o = '0;
      a = r.addr; // see R15
      ext_ok = (r.master == sad_pkg::SAD_M_CPU) || (r.master == sad_pkg::SAD_M_DMA3); // see R8
      o.valid = r.valid;
      o.target = sad_pkg::SAD_T_NONE;
      if (r.io) begin
         o.io_addr = a[15:0];
         if (io_ok(r.master, a[15:0]) && (a[23:16] == 8'h00)) begin
            o.target = sad_pkg::SAD_T_IO; // see R10
         end
      end else if (a < `SAD_MMR_END) begin
         o.target = sad_pkg::SAD_T_NONE; // see R5
      end else if (a < `SAD_SINGLE_BASE) begin
         if (r.master != sad_pkg::SAD_M_USB) begin
            o.target = sad_pkg::SAD_T_DUAL; // see R5 R9
         end
         o.block = {2'b00, a[15:13]}; // see R6
      end else if (a < `SAD_RSV_BASE) begin
         o.target = sad_pkg::SAD_T_SINGLE;
         o.block = 5'(((a - `SAD_SINGLE_BASE) >> 13)); // see R7
      end else if (a >= `SAD_ROM_BASE && !remap) begin
         o.target = sad_pkg::SAD_T_ROM; // see R4
      end else if (a >= `SAD_CS5_BASE) begin
         if (ext_ok) o.target = sad_pkg::SAD_T_CS5; // see R2 R4
      end else if (a >= `SAD_CS4_BASE) begin
         if (ext_ok) o.target = sad_pkg::SAD_T_CS4; // see R1
      end else if (a >= `SAD_CS3_BASE) begin
         if (ext_ok) o.target = sad_pkg::SAD_T_CS3; // see R1
      end else if (a >= `SAD_CS2_BASE) begin
         if (ext_ok) o.target = sad_pkg::SAD_T_CS2; // see R1
      end
      case (o.target)
         sad_pkg::SAD_T_CS2: o.cs = 4'b0001;
         sad_pkg::SAD_T_CS3: o.cs = 4'b0010;
         sad_pkg::SAD_T_CS4: o.cs = 4'b0100;
         sad_pkg::SAD_T_CS5: o.cs = 4'b1000;
         default: o.cs = 4'b0000; // see R3
      endcase
      o.ext_addr = a[`SAD_EXT_ADDR_BITS-1:0]; // see R14
      o.miss = r.valid && (o.target == sad_pkg::SAD_T_NONE); // see R18
      if (!r.valid) begin
         o.target = sad_pkg::SAD_T_NONE;
         o.cs = 4'b0000;
      end
      return o;
   endfunction

   wire sad_pkg::sad_rsp_s dec_a = decode(req_a_i, rom_remap_bit_q);
   wire sad_pkg::sad_rsp_s dec_b = decode(req_b_i, rom_remap_bit_q);

   // single-access contention; dual blocks take both ports freely
   wire single_a = dec_a.target == sad_pkg::SAD_T_SINGLE;
   wire single_b = dec_b.target == sad_pkg::SAD_T_SINGLE;
   wire same_blk = single_a && single_b && (dec_a.block == dec_b.block);
   wire [`SAD_SINGLE_BLOCKS-1:0] want_a = single_a ? (`SAD_SINGLE_BLOCKS'(1) << dec_a.block) : '0;
   wire [`SAD_SINGLE_BLOCKS-1:0] want_b = single_b ? (`SAD_SINGLE_BLOCKS'(1) << dec_b.block) : '0;
   logic [`SAD_SINGLE_BLOCKS-1:0] gnt_a;
   logic [`SAD_SINGLE_BLOCKS-1:0] gnt_b;

   genvar gi;
   generate
      for (gi = 0; gi < `SAD_SINGLE_BLOCKS; gi++) begin : g_arb
         sad_single_arb u_arb (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .req_a_i(want_a[gi]),
            .req_b_i(want_b[gi]),
            .grant_a_o(gnt_a[gi]),
            .grant_b_o(gnt_b[gi])
         );
      end
   endgenerate

   wire lose_a = single_a && ~|(gnt_a & want_a); // see R7
   wire lose_b = single_b && ~|(gnt_b & want_b); // see R7

   // external selects: b loses to a only when both address the same region
   wire [3:0] cs_a = dec_a.cs;
   wire [3:0] cs_b = (dec_b.cs & ~cs_a);
   wire cs_clash_b = |(dec_b.cs & cs_a);

   // software reset deliberately absent here so the remap bit survives it
   wire remap_d = remap_wr_i ? remap_val_i : rom_remap_bit_q; // see R17

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rom_remap_bit_q <= 1'b0; // see R16
         bus8_q <= 1'b0;
         rsp_a_q <= '0;
         rsp_b_q <= '0;
         stall_a_q <= 1'b0;
         stall_b_q <= 1'b0;
         sel_q <= 4'b0000;
      end else begin
         rom_remap_bit_q <= remap_d;
         bus8_q <= ext_bus8_i; // see R14
         rsp_a_q <= lose_a ? '0 : dec_a;
         rsp_b_q <= (lose_b || cs_clash_b) ? '0 : dec_b;
         stall_a_q <= lose_a;
         stall_b_q <= lose_b || cs_clash_b;
         sel_q <= soft_rst_i ? 4'b0000 : (cs_a | cs_b); // see R3
      end
   end

   assign rom_remap_bit_o = rom_remap_bit_q;
   assign ext_bus8_o = bus8_q;
   assign rsp_a_o = rsp_a_q;
   assign rsp_b_o = rsp_b_q;
   assign stall_a_o = stall_a_q;
   assign stall_b_o = stall_b_q;
   assign external_region_select_o = sel_q;

   a_remap_reset: assert property (@(posedge core_clk_i)
      $rose(rst_b_i) |-> !rom_remap_bit_o) else $error("remap set after reset"); // see R16
   a_remap_soft_keep: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      soft_rst_i && !remap_wr_i |=> $stable(rom_remap_bit_o)) else $error("soft reset hit remap"); // see R17
   a_rom_when_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      req_a_i.valid && !req_a_i.io && req_a_i.addr >= `SAD_ROM_BASE && !rom_remap_bit_o
      && !remap_wr_i |=> rsp_a_o.target == sad_pkg::SAD_T_ROM) else $error("rom not hit"); // see R4
   a_ext_dma_block: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      req_a_i.valid && (req_a_i.master == sad_pkg::SAD_M_DMA1) |=> rsp_a_o.cs == 4'b0000)
      else $error("dma1 reached external"); // see R8
   a_usb_no_dual: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      req_b_i.valid && req_b_i.master == sad_pkg::SAD_M_USB |=> rsp_b_o.target != sad_pkg::SAD_T_DUAL)
      else $error("usb reached dual ram"); // see R9
   a_mmr_miss: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      req_a_i.valid && !req_a_i.io && req_a_i.addr < `SAD_MMR_END |=> rsp_a_o.miss)
      else $error("core register area decoded"); // see R5
   a_sel_onehot: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      $onehot0(rsp_a_o.cs) && !(rsp_a_o.miss && |rsp_a_o.cs)) else $error("bad select"); // see R3
   a_cs2_window: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      req_a_i.valid && !req_a_i.io && req_a_i.master == sad_pkg::SAD_M_CPU
      && req_a_i.addr >= `SAD_CS2_BASE && req_a_i.addr < `SAD_CS3_BASE && !soft_rst_i
      |=> external_region_select_o[0]) else $error("cs2 not selected"); // see R1
   a_dual_both: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      dec_a.target == sad_pkg::SAD_T_DUAL && dec_b.target == sad_pkg::SAD_T_DUAL
      |=> !stall_a_o && !stall_b_o) else $error("dual ram stalled"); // see R6
   a_single_serial: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      same_blk |=> stall_a_o != stall_b_o) else $error("block clash not serialised"); // see R7
   a_io_dma_limit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      req_b_i.valid && req_b_i.io && req_b_i.master == sad_pkg::SAD_M_DMA0
      && req_b_i.addr[15:0] == 16'h1800 |=> rsp_b_o.miss) else $error("dma reached timer"); // see R12

   c_rom_hit: cover property (@(posedge core_clk_i) rsp_a_o.target == sad_pkg::SAD_T_ROM);
   c_remap_cs5: cover property (@(posedge core_clk_i)
      rom_remap_bit_o && rsp_a_o.target == sad_pkg::SAD_T_CS5);
   c_single_clash: cover property (@(posedge core_clk_i) same_blk);
   c_io_access: cover property (@(posedge core_clk_i) rsp_b_o.target == sad_pkg::SAD_T_IO);
endmodule
`default_nettype wire

// *** sad_master_bfm.sv ***
// bus master model driving one request port of the decoder
`timescale 1ns/100ps
`default_nettype none
module sad_master_bfm (
   input wire logic clk_i,
   output var sad_pkg::sad_req_s req_o
);
   initial req_o = '0;
   // offers any I/O word it is given, mapped or not; peripherals assumed out of reset and clocked
   task automatic put(input sad_pkg::sad_master_e m, input logic io, input logic [23:0] a);
      @(negedge clk_i);
      req_o.valid = 1'b1;
      req_o.master = m;
      req_o.io = io;
      req_o.addr = a;
   endtask
   // a released address flips so a stale value never looks current
   task automatic drop();
      req_o.valid = 1'b0;
      req_o.addr = ~req_o.addr;
   endtask
endmodule
`default_nettype wire

// *** tb_sad_decoder.sv ***
// self-checking testbench for the system address decoder
`timescale 1ns/100ps
`default_nettype none
module tb_sad_decoder;
   localparam sad_pkg::sad_master_e CPU = sad_pkg::SAD_M_CPU;
   localparam sad_pkg::sad_master_e D0 = sad_pkg::SAD_M_DMA0;
   localparam sad_pkg::sad_master_e D3 = sad_pkg::SAD_M_DMA3;
   localparam sad_pkg::sad_master_e USB = sad_pkg::SAD_M_USB;
   localparam sad_pkg::sad_target_e NO = sad_pkg::SAD_T_NONE;
   localparam sad_pkg::sad_target_e IO = sad_pkg::SAD_T_IO;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic soft_rst_i = 1'b0;
   logic remap_wr_i = 1'b0;
   logic remap_val_i = 1'b0;
   logic ext_bus8_i = 1'b0;
   sad_pkg::sad_req_s req_a;
   sad_pkg::sad_req_s req_b;
   sad_pkg::sad_rsp_s rsp_a;
   sad_pkg::sad_rsp_s rsp_b;
   logic remap;
   logic bus8;
   logic stall_a;
   logic stall_b;
   logic [3:0] sel;
   int errors = 0;
   int compares = 0;
   always #5 core_clk_i = ~core_clk_i;
   sad_master_bfm ma (.clk_i(core_clk_i), .req_o(req_a));
   sad_master_bfm mb (.clk_i(core_clk_i), .req_o(req_b));
   sad_decoder uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i),
      .remap_wr_i(remap_wr_i), .remap_val_i(remap_val_i), .ext_bus8_i(ext_bus8_i),
      .req_a_i(req_a), .req_b_i(req_b), .rom_remap_bit_o(remap), .ext_bus8_o(bus8),
      .rsp_a_o(rsp_a), .rsp_b_o(rsp_b), .stall_a_o(stall_a), .stall_b_o(stall_b),
      .external_region_select_o(sel));
   task automatic end_sim;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_t(input sad_pkg::sad_target_e got, input sad_pkg::sad_target_e exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: target %0d, expected %0d", $time, got, exp);
      end
   endtask
   task automatic chk_v(input logic [4:0] got, input logic [4:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: value %0h, expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk_a(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: address %0h, expected %0h", $time, got, exp);
      end
   endtask
   task automatic hw_reset;
      rst_b_i = 1'b0;
      repeat (6) @(negedge core_clk_i);
      rst_b_i = 1'b1;
   endtask
   // one access on port a; select lines derive from the expected target
   task automatic xfer(input sad_pkg::sad_master_e m, input logic io, input logic [23:0] a,
                       input sad_pkg::sad_target_e t);
      logic [3:0] cs;
      cs = (t >= sad_pkg::SAD_T_CS2 && t <= sad_pkg::SAD_T_CS5) ?
           4'h1 << (t - sad_pkg::SAD_T_CS2) : 4'h0;
      ma.put(m, io, a);
      @(negedge core_clk_i);
      chk_t(rsp_a.target, t);
      chk_v({1'b0, rsp_a.cs}, {1'b0, cs});
      chk_v({1'b0, sel}, {1'b0, cs});
      chk_v({4'h0, rsp_a.miss}, {4'h0, t == NO});
      chk_v({4'h0, rsp_a.valid}, 5'h1);
      chk_v({4'h0, stall_a}, 5'h0);
      if (cs != 4'h0) chk_a({3'h0, rsp_a.ext_addr}, {3'h0, a[20:0]});
      if (t == IO) chk_a({8'h00, rsp_a.io_addr}, {8'h00, a[15:0]});
      ma.drop();
   endtask
   task automatic pair(input logic [23:0] aa, input logic [23:0] ba, input logic [1:0] st);
      fork
         ma.put(CPU, 1'b0, aa);
         mb.put(D3, 1'b0, ba);
      join
      @(negedge core_clk_i);
      chk_v({3'h0, stall_a, stall_b}, {3'h0, st});
      if (st[0]) chk_v({4'h0, rsp_b !== '0}, 5'h0);
      ma.drop();
      mb.drop();
   endtask
   task automatic t_map;
      chk_v({4'h0, remap}, 5'h0);
      xfer(CPU, 1'b0, 24'h80_0000, sad_pkg::SAD_T_CS2);
      xfer(CPU, 1'b0, 24'hBF_FFFF, sad_pkg::SAD_T_CS2);
      xfer(CPU, 1'b0, 24'hC0_0000, sad_pkg::SAD_T_CS3);
      xfer(CPU, 1'b0, 24'hE0_0000, sad_pkg::SAD_T_CS4);
      xfer(CPU, 1'b0, 24'hF0_0000, sad_pkg::SAD_T_CS5);
      xfer(CPU, 1'b0, 24'hFD_FFFF, sad_pkg::SAD_T_CS5);
      xfer(CPU, 1'b0, 24'hFE_0000, sad_pkg::SAD_T_ROM);
      xfer(CPU, 1'b0, 24'hFF_FFFF, sad_pkg::SAD_T_ROM);
      xfer(CPU, 1'b0, 24'h7F_FFFF, NO);
      xfer(CPU, 1'b0, 24'h04_0000, NO);
   endtask
   task automatic t_ram;
      xfer(CPU, 1'b0, 24'h00_0000, NO);
      xfer(CPU, 1'b0, 24'h00_00BF, NO);
      xfer(CPU, 1'b0, 24'h00_00C0, sad_pkg::SAD_T_DUAL);
      xfer(CPU, 1'b0, 24'h00_E000, sad_pkg::SAD_T_DUAL);
      chk_v(rsp_a.block, 5'h07);
      xfer(CPU, 1'b0, 24'h03_FFFF, sad_pkg::SAD_T_SINGLE);
      pair(24'h00_00C0, 24'h00_01C0, 2'b00);
      pair(24'h01_0000, 24'h01_2000, 2'b00);
      pair(24'h01_0000, 24'h01_0100, 2'b01);
      pair(24'h01_0000, 24'h01_0100, 2'b10);
   endtask
   task automatic t_master;
      xfer(D0, 1'b0, 24'h80_0000, NO);
      xfer(sad_pkg::SAD_M_DMA1, 1'b0, 24'hC0_0000, NO);
      xfer(sad_pkg::SAD_M_DMA2, 1'b0, 24'hF0_0000, NO);
      xfer(D3, 1'b0, 24'h80_0000, sad_pkg::SAD_T_CS2);
      xfer(USB, 1'b0, 24'h00_00C0, NO);
      xfer(USB, 1'b0, 24'h01_0000, sad_pkg::SAD_T_SINGLE);
   endtask
   task automatic t_io;
      xfer(CPU, 1'b1, 24'h00_0000, IO);
      xfer(CPU, 1'b1, 24'h00_1800, IO);
      xfer(D0, 1'b1, 24'h00_1A00, IO);
      xfer(D0, 1'b1, 24'h00_1B1F, IO);
      xfer(D3, 1'b1, 24'h00_2B40, IO);
      xfer(D0, 1'b1, 24'h00_3A00, IO);
      xfer(D0, 1'b1, 24'h00_1000, IO);
      xfer(D0, 1'b1, 24'h00_8000, IO);
      xfer(D0, 1'b1, 24'h00_1800, NO);
   endtask
   task automatic t_remap;
      remap_wr_i = 1'b1;
      remap_val_i = 1'b1;
      @(negedge core_clk_i);
      remap_wr_i = 1'b0;
      xfer(CPU, 1'b0, 24'hFE_0000, sad_pkg::SAD_T_CS5);
      soft_rst_i = 1'b1;
      @(negedge core_clk_i);
      soft_rst_i = 1'b0;
      chk_v({4'h0, remap}, 5'h1);
      hw_reset();
      chk_v({4'h0, remap}, 5'h0);
      xfer(CPU, 1'b0, 24'hFE_0000, sad_pkg::SAD_T_ROM);
   endtask
   task automatic t_bus8;
      ext_bus8_i = 1'b1;
      @(negedge core_clk_i);
      chk_v({4'h0, bus8}, 5'h1);
      ext_bus8_i = 1'b0;
      @(negedge core_clk_i);
      chk_v({4'h0, bus8}, 5'h0);
   endtask
   // whole run is well under 200 accesses of a few cycles each
   initial begin
      #100000;
      errors++;
      end_sim();
   end
   initial begin
      hw_reset();
      t_map();
      t_ram();
      t_master();
      t_io();
      t_remap();
      t_bus8();
      end_sim();
   end
endmodule
`default_nettype wire
